//--- design/pcs_pkg.sv
// constants for the instruction sequencer: vectors, widths, phases, register offset
// assumes a single 40 MHz core clock and a synchronous active-high reset
//
// Contract
// - four internal phases sequence each instruction cycle
// - instruction cycle lasts exactly four clocks
// - fetch next overlaps execute of current
// - flow-changing instructions take two cycles
// - pointer advances by one after fetch
// - pointer is ten bits wide
// - transfers load event target; jumps take ten bits
// - true skip flushes next, resumes at plus two
// - low byte readable and writable at 06H
// - low byte write keeps bits nine, eight
// - every transfer inserts one dummy cycle
// - reset loads pointer with zero
// - external interrupt loads vector 004H
// - timer overflow interrupt loads vector 008H
// - returns reload pointer from saved stack entry
// ==================================================
// package
package pcs_pkg;
   localparam int          PTR_W        = 10;
   localparam int          INSN_W       = 14;
   localparam int          DATA_W       = 8;
   localparam int          ADDR_W       = 7;
   localparam int          PHASES       = 4;
   localparam int          CLK_PERIOD_NS = 25;
   localparam logic [6:0]  LOW_BYTE_ADDR = 7'h06;
   localparam logic [9:0]  RESET_VECTOR = 10'h000;
   localparam logic [9:0]  EXT_VECTOR   = 10'h004;
   localparam logic [9:0]  TMR_VECTOR   = 10'h008;
   localparam logic [1:0]  PHASE_LAST   = 2'h3;
   localparam logic [9:0]  PTR_STEP     = 10'h001;

   // kind of redirect requested by the execute stage for this cycle
   typedef enum logic [2:0] {
      PCS_NONE, PCS_JUMP, PCS_SKIP, PCS_RET, PCS_EXT, PCS_TMR
   } pcs_redirect_t;
endpackage

//--- design/pcs_phase_gen.sv
// four-phase generator: splits the core clock into one-hot phase enables
// assumes it shares the sequencer's clock and reset
`timescale 1ns/100ps
module pcs_phase_gen (
   // clock and reset
   input  wire logic       i_core_clk,
   input  wire logic       i_rst,
   // phase outputs
   output logic [1:0]      o_phase,
   output logic [3:0]      o_phase_onehot,
   output logic            o_cycle_end
);
   // ==================================================
   // phase counter
   always_ff @(posedge i_core_clk) begin
      if (i_rst) begin
         o_phase <= 2'h0;
      end else begin
         o_phase <= o_phase + 2'h1;
      end
   end

   // non-overlapping by construction: exactly one bit set per clock
   genvar g;
   generate
      for (g = 0; g < pcs_pkg::PHASES; g++) begin : g_ph
         assign o_phase_onehot[g] = (o_phase == 2'(g));
      end
   endgenerate

   assign o_cycle_end = (o_phase == pcs_pkg::PHASE_LAST);

   property p_cycle_four;
      @(posedge i_core_clk) disable iff (i_rst)
         o_cycle_end |=> !o_cycle_end [*3] ##1 o_cycle_end;
   endproperty
   a_cycle_four: assert property (p_cycle_four) else $error("cycle not four clocks");
endmodule

//--- design/pcs_sequencer.sv
// program counter sequencer: two-stage fetch/execute pipeline over a 10-bit pointer
// assumes a synchronous program memory read answered within the instruction cycle,
// and that the execute decoder presents redirect requests on the last phase
`timescale 1ns/100ps
module pcs_sequencer #(
   parameter int PTR_W  = pcs_pkg::PTR_W,
   parameter int INSN_W = pcs_pkg::INSN_W
) (
   // clock and reset
   input  wire logic              i_core_clk,
   input  wire logic              i_rst,
   // program memory
   output logic [PTR_W-1:0]       o_rom_addr,
   output logic                   o_rom_rd,
   input  wire logic [INSN_W-1:0] i_rom_data,
   // execute-stage redirect requests, sampled at cycle end
   input  wire logic              i_jump,
   input  wire logic [PTR_W-1:0]  i_jump_target,
   input  wire logic              i_skip_true,
   input  wire logic              i_ret,
   input  wire logic [PTR_W-1:0]  i_stack_top,
   input  wire logic              i_ext_irq_ack,
   input  wire logic              i_tmr_irq_ack,
   // data-memory access to the low counter byte
   input  wire logic [6:0]        i_data_addr,
   input  wire logic              i_data_wr,
   input  wire logic [7:0]        i_data_wdata,
   output logic [7:0]             o_counter_low_byte,
   // pipeline outputs
   output logic [INSN_W-1:0]      o_exec_insn,
   output logic                   o_exec_valid,
   output logic                   o_dummy,
   output logic [PTR_W-1:0]       o_instruction_pointer,
   output logic [PTR_W-1:0]       o_push_value,
   output logic [1:0]             o_phase,
   output logic                   o_cycle_end
);
   // ==================================================
   // declarations
   logic [3:0]                 phase_onehot;
   logic [PTR_W-1:0]           instruction_pointer;
   logic [PTR_W-1:0]           next_instruction_pointer;
   logic [INSN_W-1:0]          fetch_word;
   logic                       flush;
   logic                       low_wr;
   pcs_pkg::pcs_redirect_t     redirect;
   logic [2:0]                 clks_since_end;

   // ==================================================
   // phase generator
   pcs_phase_gen u_phase (
      .i_core_clk     (i_core_clk),
      .i_rst          (i_rst),
      .o_phase        (o_phase),
      .o_phase_onehot (phase_onehot),
      .o_cycle_end    (o_cycle_end)
   );

   // ==================================================
   // redirect priority: interrupts win, then returns, jumps, skips
   function automatic pcs_pkg::pcs_redirect_t pick_redirect(
      input logic ext, input logic tmr, input logic ret,
      input logic jmp, input logic skp);
      pcs_pkg::pcs_redirect_t r;
      r = pcs_pkg::PCS_NONE;
      if (ext) begin
         r = pcs_pkg::PCS_EXT;
      end else if (tmr) begin
         r = pcs_pkg::PCS_TMR;
      end else if (ret) begin
         r = pcs_pkg::PCS_RET;
      end else if (jmp) begin
         r = pcs_pkg::PCS_JUMP;
      end else if (skp) begin
         r = pcs_pkg::PCS_SKIP;
      end
      return r;
   endfunction

   // a dummy cycle never redirects: its word is dead
   assign redirect = o_dummy ? pcs_pkg::PCS_NONE
                   : pick_redirect(i_ext_irq_ack, i_tmr_irq_ack, i_ret, i_jump, i_skip_true);
   assign low_wr   = i_data_wr && (i_data_addr == pcs_pkg::LOW_BYTE_ADDR) && !o_dummy;

   // ==================================================
   // next pointer
   always_comb begin
      next_instruction_pointer = instruction_pointer + pcs_pkg::PTR_STEP;
      flush = 1'b0;
      case (redirect)
         pcs_pkg::PCS_EXT: begin
            next_instruction_pointer = pcs_pkg::EXT_VECTOR;
            flush = 1'b1;
         end
         pcs_pkg::PCS_TMR: begin
            next_instruction_pointer = pcs_pkg::TMR_VECTOR;
            flush = 1'b1;
         end
         pcs_pkg::PCS_RET: begin
            next_instruction_pointer = i_stack_top;
            flush = 1'b1;
         end
         pcs_pkg::PCS_JUMP: begin
            next_instruction_pointer = i_jump_target;
            flush = 1'b1;
         end
         pcs_pkg::PCS_SKIP: begin
            // pointer holds the flushed word's address; plain step lands on plus two
            flush = 1'b1;
         end
         default: begin
            flush = 1'b0;
         end
      endcase
      if (low_wr && (redirect == pcs_pkg::PCS_NONE || redirect == pcs_pkg::PCS_SKIP)) begin
         // written byte beats the increment, page bits stay
         next_instruction_pointer = {instruction_pointer[PTR_W-1:8], i_data_wdata};
         flush = 1'b1;
      end
   end

   // ==================================================
   // pointer register, updated once per instruction cycle
   always_ff @(posedge i_core_clk) begin
      if (i_rst) begin
         instruction_pointer <= pcs_pkg::RESET_VECTOR;
      end else if (o_cycle_end) begin
         instruction_pointer <= next_instruction_pointer;
      end
   end

   // ==================================================
   // fetch stage: read issued on phase 0, word captured on phase 2
   always_ff @(posedge i_core_clk) begin
      if (i_rst) begin
         fetch_word <= '0;
      end else if (phase_onehot[2]) begin
         fetch_word <= i_rom_data;
      end
   end

   // ==================================================
   // execute stage: fetched word moves in at cycle end
   always_ff @(posedge i_core_clk) begin
      if (i_rst) begin
         o_exec_insn  <= '0;
         o_exec_valid <= 1'b0;
         o_dummy      <= 1'b1;
      end else if (o_cycle_end) begin
         o_exec_insn  <= fetch_word;
         o_exec_valid <= !flush;
         // flushed word runs as a no-op: one lost cycle per transfer
         o_dummy      <= flush;
      end
   end

   // push value: address of the instruction after the executing one
   always_ff @(posedge i_core_clk) begin
      if (i_rst) begin
         o_push_value <= '0;
      end else if (o_cycle_end) begin
         o_push_value <= next_instruction_pointer;
      end
   end

   assign o_rom_addr            = instruction_pointer;
   assign o_rom_rd              = phase_onehot[0];
   assign o_instruction_pointer = instruction_pointer;
   assign o_counter_low_byte    = instruction_pointer[7:0];

   // ==================================================
   // checks
   property p_step_one;
      @(posedge i_core_clk) disable iff (i_rst)
         (o_cycle_end && redirect == pcs_pkg::PCS_NONE && !low_wr)
            |=> instruction_pointer == $past(instruction_pointer) + pcs_pkg::PTR_STEP;
   endproperty
   a_step_one: assert property (p_step_one) else $error("pointer did not step by one");

   property p_jump_load;
      @(posedge i_core_clk) disable iff (i_rst)
         (o_cycle_end && redirect == pcs_pkg::PCS_JUMP)
            |=> instruction_pointer == $past(i_jump_target) && o_dummy;
   endproperty
   a_jump_load: assert property (p_jump_load) else $error("jump target not loaded");

   property p_ext_vec;
      @(posedge i_core_clk) disable iff (i_rst)
         (o_cycle_end && redirect == pcs_pkg::PCS_EXT) |=> instruction_pointer == 10'h004;
   endproperty
   a_ext_vec: assert property (p_ext_vec) else $error("external vector wrong");

   property p_tmr_vec;
      @(posedge i_core_clk) disable iff (i_rst)
         (o_cycle_end && redirect == pcs_pkg::PCS_TMR) |=> instruction_pointer == 10'h008;
   endproperty
   a_tmr_vec: assert property (p_tmr_vec) else $error("timer vector wrong");

   property p_ret_load;
      @(posedge i_core_clk) disable iff (i_rst)
         (o_cycle_end && redirect == pcs_pkg::PCS_RET) |=> instruction_pointer == $past(i_stack_top);
   endproperty
   a_ret_load: assert property (p_ret_load) else $error("return address not loaded");

   property p_skip_two;
      @(posedge i_core_clk) disable iff (i_rst)
         (o_cycle_end && redirect == pcs_pkg::PCS_SKIP && !low_wr)
            |=> ##3 o_cycle_end ##1 (instruction_pointer == $past(instruction_pointer, 5) + 10'h002);
   endproperty
   a_skip_two: assert property (p_skip_two) else $error("skip did not reach plus two");

   property p_low_write;
      @(posedge i_core_clk) disable iff (i_rst)
         (o_cycle_end && low_wr && redirect == pcs_pkg::PCS_NONE)
            |=> instruction_pointer == {$past(instruction_pointer[9:8]), $past(i_data_wdata)};
   endproperty
   a_low_write: assert property (p_low_write) else $error("low byte write wrong");

   property p_dummy_len;
      @(posedge i_core_clk) disable iff (i_rst)
         $rose(o_dummy) |-> o_dummy [*4] ##1 !o_dummy;
   endproperty
   a_dummy_len: assert property (p_dummy_len) else $error("dummy shorter than a cycle");

   property p_dummy_noop;
      @(posedge i_core_clk) disable iff (i_rst)
         o_dummy |-> !o_exec_valid && redirect == pcs_pkg::PCS_NONE;
   endproperty
   a_dummy_noop: assert property (p_dummy_noop) else $error("dummy cycle had effect");

   property p_reset_zero;
      @(posedge i_core_clk) $fell(i_rst) |-> instruction_pointer == 10'h000;
   endproperty
   a_reset_zero: assert property (p_reset_zero) else $error("reset pointer not zero");

   // ==================================================
   // helper: clocks since the last cycle end, kept apart from the phase counter
   always_ff @(posedge i_core_clk) begin
      if (i_rst || o_cycle_end) begin
         clks_since_end <= 3'h0;
      end else begin
         clks_since_end <= clks_since_end + 3'h1;
      end
   end

   property p_cycle_bound;
      @(posedge i_core_clk) disable iff (i_rst)
         clks_since_end <= {1'b0, pcs_pkg::PHASE_LAST}
            && o_cycle_end == (clks_since_end == {1'b0, pcs_pkg::PHASE_LAST});
   endproperty
   a_cycle_bound: assert property (p_cycle_bound) else $error("cycle end out of step");

   // ==================================================
   // flow and pipeline checks
   property p_dummy_inert;
      @(posedge i_core_clk) disable iff (i_rst)
         (o_dummy && o_cycle_end)
            |=> !o_dummy
                && instruction_pointer == $past(instruction_pointer) + pcs_pkg::PTR_STEP;
   endproperty
   a_dummy_inert: assert property (p_dummy_inert) else $error("dummy not inert");

   property p_addr_stand;
      @(posedge i_core_clk) disable iff (i_rst)
         !o_cycle_end |=> $stable(o_rom_addr);
   endproperty
   a_addr_stand: assert property (p_addr_stand) else $error("fetch address moved");

   property p_exec_stand;
      @(posedge i_core_clk) disable iff (i_rst)
         !o_cycle_end
            |=> $stable(o_exec_insn) && $stable(o_exec_valid) && $stable(o_dummy);
   endproperty
   a_exec_stand: assert property (p_exec_stand) else $error("exec stage moved");

   property p_flow_two;
      @(posedge i_core_clk) disable iff (i_rst)
         (o_cycle_end && redirect != pcs_pkg::PCS_NONE) |=> o_dummy [*4] ##1 !o_dummy;
   endproperty
   a_flow_two: assert property (p_flow_two) else $error("redirect not two cycles");

   property p_low_skip;
      @(posedge i_core_clk) disable iff (i_rst)
         (o_cycle_end && low_wr && redirect == pcs_pkg::PCS_SKIP)
            |=> instruction_pointer == {$past(instruction_pointer[9:8]), $past(i_data_wdata)}
                && o_dummy;
   endproperty
   a_low_skip: assert property (p_low_skip) else $error("write lost to skip");

   property p_fetch_once;
      @(posedge i_core_clk) disable iff (i_rst)
         o_rom_rd |=> !o_rom_rd [*3] ##1 o_rom_rd;
   endproperty
   a_fetch_once: assert property (p_fetch_once) else $error("strobe not once");

   property p_exec_next;
      @(posedge i_core_clk) disable iff (i_rst)
         (o_cycle_end && !o_dummy && redirect == pcs_pkg::PCS_NONE && !low_wr)
            |=> o_exec_valid && !o_dummy && o_exec_insn == $past(fetch_word);
   endproperty
   a_exec_next: assert property (p_exec_next) else $error("word not executed");

   property p_reset_state;
      @(posedge i_core_clk)
         i_rst |=> instruction_pointer == 10'h000 && o_phase == 2'h0
                   && o_dummy && !o_exec_valid;
   endproperty
   a_reset_state: assert property (p_reset_state) else $error("reset state wrong");
endmodule

//--- verification/pcs_rom_model.sv
// program memory model: answers each fetch with a word derived from its address
// assumes the fetch strobe is high for one clock at the start of each instruction cycle
`timescale 1ns/100ps
module pcs_rom_model (
   // clock
   input  wire logic        i_core_clk,
   // fetch side
   input  wire logic        i_rd,
   input  wire logic [9:0]  i_addr,
   input  wire logic        i_slow,
   output logic      [13:0] o_data
);
   // ==========
   // read timing
   logic [9:0]  addr_q = 10'h000;
   logic [1:0]  age    = 2'h3;
   logic [13:0] word;
   always_ff @(posedge i_core_clk) begin
      if (i_rd) begin
         addr_q <= i_addr;
         age    <= 2'h0;
      end else if (age != 2'h3) begin
         age <= age + 2'h1;
      end
   end
   assign word = {addr_q[3:0] ^ 4'h5, addr_q};
   // stale data is inverted so a late sample never matches by chance
   assign o_data = ((age == 2'h1) || (age == 2'h0 && !i_slow)) ? word : ~word;
endmodule

//--- verification/program_counter_sequencer_test.sv
// self-checking bench for the sequencer: drives redirect requests at cycle end
// assumes the program memory model in pcs_rom_model and a 40 MHz clock
`timescale 1ns/100ps
`define CHK(nm, ex, got) begin tests_run++; if ((got) !== (ex)) begin n_mismatch++; \
   $display("unexpected %s: expected %h seen %h", nm, ex, got); end end
module program_counter_sequencer_test;
   // ==========
   // signals
   logic        i_core_clk = 1'b0;
   logic        i_rst      = 1'b1;
   logic        slow       = 1'b1;
   logic [4:0]  r          = 5'h00;
   logic [9:0]  tgt        = 10'h000;
   logic [9:0]  stk        = 10'h000;
   logic [6:0]  d_addr     = 7'h00;
   logic        d_wr       = 1'b0;
   logic [7:0]  d_wdata    = 8'h00;
   logic [9:0]  rom_addr, ptr, exp_ptr, prev, push;
   logic [13:0] rom_data, exec_insn;
   logic        rom_rd, exec_valid, dummy, cyc_end;
   logic [7:0]  low_byte;
   logic [1:0]  phase;
   logic [4:0]  codes [4] = '{5'h1b, 5'h0e, 5'h07, 5'h03};
   logic [9:0]  vecs [4]  = '{10'h004, 10'h008, 10'h15a, 10'h2a5};
   int          n_mismatch = 0;
   int          tests_run  = 0;
   int          cycles     = 0;
   always #12.5 i_core_clk = ~i_core_clk;
   // ==========
   // design and memory
   pcs_sequencer i_dut (
      .i_core_clk(i_core_clk), .i_rst(i_rst), .o_rom_addr(rom_addr), .o_rom_rd(rom_rd),
      .i_rom_data(rom_data), .i_jump(r[1]), .i_jump_target(tgt), .i_skip_true(r[0]),
      .i_ret(r[2]), .i_stack_top(stk), .i_ext_irq_ack(r[4]), .i_tmr_irq_ack(r[3]),
      .i_data_addr(d_addr), .i_data_wr(d_wr), .i_data_wdata(d_wdata),
      .o_counter_low_byte(low_byte), .o_exec_insn(exec_insn), .o_exec_valid(exec_valid),
      .o_dummy(dummy), .o_instruction_pointer(ptr), .o_push_value(push), .o_phase(phase),
      .o_cycle_end(cyc_end));
   pcs_rom_model i_rom (.i_core_clk(i_core_clk), .i_rd(rom_rd), .i_addr(rom_addr),
      .i_slow(slow), .o_data(rom_data));
   // ==========
   // helpers
   function automatic logic [13:0] word_of(input logic [9:0] a);
      return {a[3:0] ^ 4'h5, a};
   endfunction
   task automatic end_of_test();
      if (n_mismatch == 0 && tests_run > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask
   // bits of rq: external, timer, return, jump, skip
   task automatic req(input logic [4:0] rq, input logic [9:0] t, input logic [6:0] a,
                      input logic w, input logic [7:0] d);
      int k;
      k = 0;
      prev = exp_ptr;
      @(negedge i_core_clk);
      while (cyc_end !== 1'b1 && k < 8) begin
         @(negedge i_core_clk);
         k++;
      end
      r = rq;
      tgt = t;
      stk = ~t;
      d_addr = a;
      d_wr = w;
      d_wdata = d;
      @(negedge i_core_clk);
      r = 5'h00;
      d_wr = 1'b0;
   endtask
   task automatic chk(input logic [9:0] e, input logic dm);
      `CHK("pointer", e, ptr)
      `CHK("fetch address", e, rom_addr)
      `CHK("push value", e, push)
      `CHK("dummy", dm, dummy)
      `CHK("exec valid", ~dm, exec_valid)
   endtask
   always @(posedge i_core_clk) begin
      cycles++;
      if (cycles == 2000) begin
         n_mismatch++;
         end_of_test();
      end
   end
   // ==========
   // sequence
   initial begin
      repeat (5) @(posedge i_core_clk);
      @(negedge i_core_clk);
      `CHK("pointer", 10'h000, ptr)
      `CHK("dummy", 1'b1, dummy)
      i_rst = 1'b0;
      for (int k = 1; k <= 8; k++) begin
         @(negedge i_core_clk);
         `CHK("phase", k[1:0], phase)
         `CHK("fetch strobe", phase == 2'h0, rom_rd)
         `CHK("cycle end", phase == 2'h3, cyc_end)
      end
      exp_ptr = 10'h002;
      chk(exp_ptr, 1'b0);
      `CHK("exec word", word_of(10'h001), exec_insn)
      for (int k = 0; k < 3; k++) begin
         slow = (k == 0);
         req(5'h00, 10'h000, 7'h00, 1'b0, 8'h00);
         exp_ptr = exp_ptr + 10'h001;
         chk(exp_ptr, 1'b0);
         `CHK("exec word", word_of(prev), exec_insn)
      end
      req(5'h02, 10'h3f0, 7'h00, 1'b0, 8'h00);
      exp_ptr = 10'h3f0;
      chk(exp_ptr, 1'b1);
      // jump during the dummy cycle must be dropped
      req(5'h02, 10'h000, 7'h00, 1'b0, 8'h00);
      exp_ptr = 10'h3f1;
      chk(exp_ptr, 1'b0);
      `CHK("exec word", word_of(10'h3f0), exec_insn)
      `CHK("low byte", exp_ptr[7:0], low_byte)
      req(5'h00, 10'h000, 7'h06, 1'b1, 8'h0a);
      exp_ptr = 10'h30a;
      chk(exp_ptr, 1'b1);
      req(5'h00, 10'h000, 7'h06, 1'b1, 8'h55);
      exp_ptr = 10'h30b;
      chk(exp_ptr, 1'b0);
      req(5'h00, 10'h000, 7'h07, 1'b1, 8'h55);
      exp_ptr = 10'h30c;
      chk(exp_ptr, 1'b0);
      req(5'h01, 10'h000, 7'h00, 1'b0, 8'h00);
      exp_ptr = 10'h30d;
      chk(exp_ptr, 1'b1);
      req(5'h00, 10'h000, 7'h00, 1'b0, 8'h00);
      exp_ptr = 10'h30e;
      `CHK("exec word", word_of(10'h30d), exec_insn)
      req(5'h01, 10'h000, 7'h06, 1'b1, 8'h40);
      exp_ptr = 10'h340;
      chk(exp_ptr, 1'b1);
      req(5'h00, 10'h000, 7'h00, 1'b0, 8'h00);
      `CHK("exec word", word_of(10'h340), exec_insn)
      for (int k = 0; k < 4; k++) begin
         req(codes[k], 10'h2a5, 7'h06, 1'b1, 8'h77);
         exp_ptr = vecs[k];
         chk(exp_ptr, 1'b1);
         req(5'h00, 10'h000, 7'h00, 1'b0, 8'h00);
         exp_ptr = exp_ptr + 10'h001;
         `CHK("exec word", word_of(vecs[k]), exec_insn)
      end
      end_of_test();
   end
endmodule
